/* File: design/ttl_consts.svh */
// constants for the trace time and level tracker
// Summary of operation
// R1: accumulate trace-enabled time per recording in half-microsecond steps
// R2: trace time spans 1638.35 s and wraps to zero on overflow
// R3: hold four-bit current trace level, current or last reached
// R4: store the active trace level beside every stored sample
// R5: trace-active output high only while armed and level tracing enabled
// R6: clock output is active-low pulse per internal master clock sample
// R7: keep 24-hour wall clock, latch it when each acquisition ends
// R8: measure external clock frequency, 100 Hz to 50 MHz, 0.1 percent
// R9: arm reinitialises acquisition control and restarts recording, even armed
// R10: stop ends recording and leaves stored contents unchanged
// R11: trace time clears on arm, advances per tick only while tracing
`ifndef TTL_CONSTS_SVH
`define TTL_CONSTS_SVH

// clock and half-microsecond tick
`define TTL_CLK_PERIOD_NS 8
`define TTL_NS_PER_US     1000
`define TTL_US_CYC        (`TTL_NS_PER_US / `TTL_CLK_PERIOD_NS)
`define TTL_TICK_A        7'((`TTL_US_CYC / 2) - 1)
`define TTL_TICK_B        7'(`TTL_US_CYC - 1)

// trace time range: 1638.35 s in half-microsecond ticks
`define TTL_HALF_US_NS    500
`define TTL_CS_NS         10000000
`define TTL_RANGE_CS      163835
`define TTL_TT_MAX        32'(`TTL_RANGE_CS * (`TTL_CS_NS / `TTL_HALF_US_NS))

// wall clock: last second of the day, one second in cycles
`define TTL_DAY_S         17'h1_517f
`define TTL_SEC_NS        1000000000
`define TTL_SEC_CYC       (`TTL_SEC_NS / `TTL_CLK_PERIOD_NS)

// frequency gate: 10 s gives 0.1 Hz units, 1000 counts at 100 Hz
`define TTL_GATE_S        10
`define TTL_GATE_CYC      (`TTL_GATE_S * `TTL_SEC_CYC)

// sample tag memory
`define TTL_TAG_AW        10
`define TTL_TAG_DEPTH     (1 << `TTL_TAG_AW)

`endif

/* File: design/ttl_pkg.sv */
// types for the trace time and level tracker
package ttl_pkg;
	typedef enum logic {
		TTL_IDLE = 1'b0,
		TTL_REC  = 1'b1
	} ttl_mode_t;

	// sequencer signals, same clock domain
	typedef struct packed {
		logic       arm;
		logic       stop;
		logic       seq_stop;
		logic       sample;
		logic       mclk_tick;
		logic       trace_en;
		logic [3:0] level;
	} ttl_seq_t;

	typedef struct packed {
		ttl_mode_t   mode;
		logic [6:0]  tick_cnt;
		logic [31:0] trace_time;
		logic [3:0]  level;
		logic [9:0]  wr_addr;
		logic        trace_act;
		logic        clk_out_n;
		logic [26:0] sec_cnt;
		logic [16:0] wall;
		logic [16:0] end_time;
		logic [30:0] gate_cnt;
		logic [28:0] edge_cnt;
		logic [28:0] freq;
		logic [2:0]  ext_sync;
		logic [3:0]  tag_rd;
	} ttl_state_t;
endpackage

/* File: design/ttl_tracker.sv */
// trace time, trace level, wall clock and external clock meter
`timescale 1ns/10ps
`include "ttl_consts.svh"

module ttl_tracker import ttl_pkg::*; #(
	parameter int unsigned SEC_CYC  = `TTL_SEC_CYC,
	parameter int unsigned GATE_CYC = `TTL_GATE_CYC
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// sequencer and acquisition control
	input  wire ttl_seq_t    i_seq,
	// wall clock preset
	input  wire logic        i_wall_set,
	input  wire logic [16:0] i_wall_value,
	// external sampling clock pin
	input  wire logic        i_ext_clk,
	// tag read-back
	input  wire logic [9:0]  i_tag_addr,
	// outputs
	output logic             o_recording,
	output logic             o_trace_active,
	output logic             o_clk_out_n,
	output logic [3:0]       o_level,
	output logic [31:0]      o_trace_time,
	output logic [16:0]      o_wall_clock,
	output logic [16:0]      o_end_time,
	output logic [28:0]      o_ext_freq,
	output logic [3:0]       o_tag_rd_data
);

	ttl_state_t  q;
	ttl_state_t  d;
	logic [3:0]  tag_mem [`TTL_TAG_DEPTH];
	// per-cycle strobes decoded from the state and the sequencer group
	logic        tick;
	logic        rec;
	logic        ending;
	logic        tag_we;
	logic        ext_rise;

	// half-microsecond tick from alternating 62 and 63 cycle spacing
	assign tick     = (q.tick_cnt == `TTL_TICK_A) || (q.tick_cnt == `TTL_TICK_B);   // [R1]
	assign rec      = (q.mode == TTL_REC);
	// recording end and tag writes are refused in an arm cycle: arm wins
	assign ending   = rec && (i_seq.stop || i_seq.seq_stop) && !i_seq.arm;
	assign tag_we   = rec && i_seq.sample && !i_seq.arm;
	assign ext_rise = q.ext_sync[1] && !q.ext_sync[2];

	// next-state logic
	always_comb begin
		d = q;
		// tick divider
		d.tick_cnt = (q.tick_cnt == `TTL_TICK_B) ? 7'h00 : q.tick_cnt + 7'h01;
		// recording control
		// arm is honoured in both states, so a second arm simply restarts
		unique case (q.mode)
			TTL_IDLE: begin
				if (i_seq.arm) begin
					d.mode = TTL_REC;   // [R9]
				end
			end
			TTL_REC: begin
				if (ending) begin
					d.mode = TTL_IDLE;   // [R10]
				end
			end
		endcase
		// trace time accumulator
		// arm has priority, so the arm cycle itself is never counted
		if (i_seq.arm) begin
			d.trace_time = 32'h0000_0000;   // [R11] [R9]
		end else if (rec && i_seq.trace_en && tick) begin
			// wrap rather than saturate once the full range is used
			if (q.trace_time == `TTL_TT_MAX) begin
				d.trace_time = 32'h0000_0000;   // [R2]
			end else begin
				d.trace_time = q.trace_time + 32'h0000_0001;   // [R1] [R11]
			end
		end
		// current level, frozen once recording ends
		if (i_seq.arm || rec) begin
			d.level = i_seq.level;   // [R3]
		end
		// tag write pointer
		// samples outside a recording are dropped, so stop leaves the tags intact
		if (i_seq.arm) begin
			d.wr_addr = 10'h000;   // [R9]
		end else if (tag_we) begin
			d.wr_addr = q.wr_addr + 10'h001;   // [R4]
		end
		// read port is registered: data follows the address one cycle later
		d.tag_rd    = tag_mem[i_tag_addr];   // [R4]
		d.trace_act = rec && i_seq.trace_en && !ending;   // [R5]
		d.clk_out_n = !i_seq.mclk_tick;   // [R6]
		// wall clock, seconds of day
		if (q.sec_cnt == 27'(SEC_CYC - 1)) begin
			d.sec_cnt = 27'h000_0000;
			d.wall    = (q.wall == `TTL_DAY_S) ? 17'h0_0000 : q.wall + 17'h0_0001;   // [R7]
		end else begin
			d.sec_cnt = q.sec_cnt + 27'h000_0001;
		end
		// preset wins over the once-per-second step in the same cycle
		if (i_wall_set) begin
			d.wall = i_wall_value;
		end
		if (ending) begin
			d.end_time = q.wall;   // [R7]
		end
		// external clock meter: count rising edges over the gate
		// ext_sync[1:0] is the two-stage synchroniser, [2] only delays for the edge
		d.ext_sync = {q.ext_sync[1:0], i_ext_clk};
		if (q.gate_cnt == 31'(GATE_CYC - 1)) begin
			d.gate_cnt = 31'h0000_0000;
			// a rise in the gate's last cycle belongs to this gate, not the next
			d.freq     = q.edge_cnt + {28'h000_0000, ext_rise};   // [R8]
			d.edge_cnt = 29'h0000_0000;
		end else begin
			d.gate_cnt = q.gate_cnt + 31'h0000_0001;
			d.edge_cnt = q.edge_cnt + {28'h000_0000, ext_rise};   // [R8]
		end
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			q           <= '0;
			q.mode      <= TTL_IDLE;
			// clock output idles high, since its pulses are active low
			q.clk_out_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// tag memory, written only while recording
	always_ff @(posedge i_core_clk) begin
		if (tag_we) begin
			tag_mem[q.wr_addr] <= i_seq.level;   // [R4] [R10]
		end
	end

	// outputs straight from the state register
	// o_recording is the one-bit mode register itself
	assign o_recording    = rec;
	assign o_trace_active = q.trace_act;
	assign o_clk_out_n    = q.clk_out_n;
	assign o_level        = q.level;
	assign o_trace_time   = q.trace_time;
	assign o_wall_clock   = q.wall;
	assign o_end_time     = q.end_time;
	assign o_ext_freq     = q.freq;
	assign o_tag_rd_data  = q.tag_rd;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// checks
	a_tick_spacing: assert property (tick |=> !tick [*8])   // [R1]
		else $error("half-us ticks too close");
	a_tt_arm_clear: assert property (i_seq.arm |=> o_trace_time == 32'h0000_0000)   // [R11]
		else $error("trace time not cleared by arm");
	a_tt_wraps: assert property (rec && !i_seq.arm && i_seq.trace_en && tick
		&& o_trace_time == `TTL_TT_MAX |=> o_trace_time == 32'h0000_0000)   // [R2]
		else $error("trace time did not wrap");
	a_tt_holds: assert property (!i_seq.arm && !(rec && i_seq.trace_en && tick)
		|=> $stable(o_trace_time))   // [R11]
		else $error("trace time moved while not tracing");
	a_trace_out: assert property (o_trace_active |-> $past(rec) && $past(i_seq.trace_en))   // [R5]
		else $error("trace output without armed trace level");
	a_level_frozen: assert property (!rec && !i_seq.arm |=> $stable(o_level))   // [R3]
		else $error("level changed after recording");
	a_clk_pulse: assert property (i_seq.mclk_tick ##1 !i_seq.mclk_tick |-> !o_clk_out_n ##1 o_clk_out_n)   // [R6]
		else $error("clock output pulse wrong");
	a_end_latch: assert property (ending |=> o_end_time == $past(o_wall_clock) && !o_recording)   // [R7]
		else $error("end time not latched");
	a_arm_restart: assert property (i_seq.arm |=> o_recording ##1 (o_recording || $past(ending)))   // [R9]
		else $error("arm did not start recording");
	a_stop_holds: assert property (!rec && !i_seq.arm |=> q.wr_addr == $past(q.wr_addr))   // [R10]
		else $error("tag pointer moved after stop");

	// trace time stepping
	a_tt_step: assert property (rec && !i_seq.arm && i_seq.trace_en && tick   // [R1]
		&& o_trace_time != `TTL_TT_MAX
		|=> o_trace_time == $past(o_trace_time) + 32'h0000_0001)
		else $error("trace time did not step by one");

	// level and trace output
	a_level_track: assert property (i_seq.arm || rec   // [R3]
		|=> o_level == $past(i_seq.level))
		else $error("level not following the sequencer");
	a_trace_low: assert property (!rec |=> !o_trace_active)   // [R5]
		else $error("trace output high while not recording");
	a_trace_high: assert property (rec && i_seq.trace_en && !ending |=> o_trace_active)   // [R5]
		else $error("trace output low while tracing");
	a_rec_idle: assert property (!rec && !i_seq.arm |=> !o_recording)   // [R10]
		else $error("recording restarted without arm");

	// clock output follows every master tick
	a_clk_low: assert property (i_seq.mclk_tick |=> !o_clk_out_n)   // [R6]
		else $error("clock output missed a tick");
	a_clk_idle: assert property (!i_seq.mclk_tick |=> o_clk_out_n)   // [R6]
		else $error("clock output low without a tick");

	// wall clock and end time
	a_wall_load: assert property (i_wall_set |=> o_wall_clock == $past(i_wall_value))   // [R7]
		else $error("wall clock preset not taken");
	a_wall_wrap: assert property (q.sec_cnt == 27'(SEC_CYC - 1) && !i_wall_set   // [R7]
		&& q.wall == `TTL_DAY_S |=> o_wall_clock == 17'h0_0000)
		else $error("wall clock did not wrap at end of day");
	a_wall_steady: assert property (q.sec_cnt != 27'(SEC_CYC - 1) && !i_wall_set   // [R7]
		|=> $stable(o_wall_clock))
		else $error("wall clock moved inside a second");
	a_end_steady: assert property (!ending |=> $stable(o_end_time))   // [R7]
		else $error("end time moved without an end");

	// frequency result only changes at the gate end
	a_freq_steady: assert property (q.gate_cnt != 31'(GATE_CYC - 1)   // [R8]
		|=> $stable(o_ext_freq))
		else $error("frequency result moved inside the gate");

	// tag write pointer
	a_tag_step: assert property (tag_we |=> q.wr_addr == $past(q.wr_addr) + 10'h001)   // [R4]
		else $error("tag pointer did not step");
	a_arm_ptr: assert property (i_seq.arm |=> q.wr_addr == 10'h000)   // [R9]
		else $error("tag pointer not cleared by arm");

endmodule // ttl_tracker

/* File: tb/ttl_seq_model.sv */
// sequencer stand-in that drives the tracker's command group
`timescale 1ns/10ps
module ttl_seq_model import ttl_pkg::*; (
	// clock
	input  wire logic i_core_clk,
	// sequencer outputs
	output ttl_seq_t  o_seq
);
	initial o_seq = '0;

	// current level and its trace enable, changed on a falling edge
	task automatic lvl(input logic [3:0] l, input logic en);
		o_seq.level = l;
		o_seq.trace_en = en;
	endtask

	// one-cycle pulse: 0 arm, 1 stop, 2 sample, 3 master tick, 4 sequencer stop
	task automatic cmd(input int k);
		@(negedge i_core_clk);
		case (k)
			0: o_seq.arm = 1'b1;
			1: o_seq.stop = 1'b1;
			2: o_seq.sample = 1'b1;
			3: o_seq.mclk_tick = 1'b1;
			default: o_seq.seq_stop = 1'b1;
		endcase
		@(negedge i_core_clk);
		o_seq = {5'h0, o_seq.trace_en, o_seq.level};
	endtask
endmodule // ttl_seq_model

/* File: tb/ttl_tracker_tb.sv */
// self-checking bench for the trace time and level tracker
`timescale 1ns/10ps
module ttl_tracker_tb import ttl_pkg::*; ;
	logic        i_core_clk, i_rst, i_wall_set, i_ext_clk;
	logic [16:0] i_wall_value, o_wall_clock, o_end_time;
	logic [9:0]  i_tag_addr;
	ttl_seq_t    i_seq;
	logic        o_recording, o_trace_active, o_clk_out_n;
	logic [3:0]  o_level, o_tag_rd_data, lv;
	logic [3:0]  tag_e [6];
	logic [31:0] o_trace_time, got, e;
	logic [28:0] o_ext_freq;
	logic [31:0] exp_q [$];
	int          sel_q [$];
	int          fails = 0;
	int          checks = 0;
	event        ev;

	ttl_tracker #(.SEC_CYC(16), .GATE_CYC(200)) dut (
		.i_core_clk     (i_core_clk),
		.i_rst          (i_rst),
		.i_seq          (i_seq),
		.i_wall_set     (i_wall_set),
		.i_wall_value   (i_wall_value),
		.i_ext_clk      (i_ext_clk),
		.i_tag_addr     (i_tag_addr),
		.o_recording    (o_recording),
		.o_trace_active (o_trace_active),
		.o_clk_out_n    (o_clk_out_n),
		.o_level        (o_level),
		.o_trace_time   (o_trace_time),
		.o_wall_clock   (o_wall_clock),
		.o_end_time     (o_end_time),
		.o_ext_freq     (o_ext_freq),
		.o_tag_rd_data  (o_tag_rd_data)
	);
	ttl_seq_model pm (.i_core_clk(i_core_clk), .o_seq(i_seq));

	// core clock and an unrelated external clock of four core cycles
	initial begin
		i_core_clk = 1'b0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	initial begin
		i_ext_clk = 1'b0;
		forever #16 i_ext_clk = ~i_ext_clk;
	end

	function automatic logic [31:0] pick(input int s);
		case (s)
			0: return 32'(o_recording);
			1: return o_trace_time;
			2: return 32'(o_end_time);
			3: return 32'(o_tag_rd_data);
			4: return 32'(o_trace_active);
			5: return 32'(o_clk_out_n);
			6: return 32'(o_level);
			8: return 32'(o_wall_clock);
			default: return 32'(o_ext_freq);
		endcase
	endfunction

	task automatic note(input logic [31:0] v, input int s);
		exp_q.push_back(v);
		sel_q.push_back(s);
		->ev;
	endtask

	// monitor: oldest note against the output it names
	always begin
		@(ev);
		#1;
		while (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			got = pick(sel_q.pop_front());
			checks++;
			if (got !== e) begin
				fails++;
				$display("unexpected at %0t: got %h expected %h", $time, got, e);
			end
		end
	end

	task automatic final_report;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		#400000;
		fails++;
		final_report();
	end

	// main sequence
	initial begin
		void'($urandom(32'h7e94_8adf));
		{i_wall_set, i_wall_value, i_tag_addr} = '0;
		i_rst = 1'b1;
		repeat (3) @(negedge i_core_clk);
		i_rst = 1'b0;
		note(32'h0, 0);
		note(32'h1, 5);
		lv = 4'($urandom);
		pm.cmd(0);
		note(32'h1, 0);
		note(32'h0, 1);
		pm.lvl(lv, 1'b1);
		repeat (500) @(negedge i_core_clk);
		note(32'h1, 4);
		note(32'(lv), 6);
		repeat (500) @(negedge i_core_clk);
		pm.lvl(lv, 1'b0);
		note(32'h10, 1);
		repeat (200) @(negedge i_core_clk);
		note(32'h0, 4);
		note(32'h10, 1);
		pm.cmd(0);
		note(32'h0, 1);
		note(32'h1, 0);
		$display("test trace time done");
		for (int i = 0; i < 6; i++) begin
			tag_e[i] = 4'($urandom);
			pm.lvl(tag_e[i], 1'b0);
			pm.cmd(2);
		end
		i_wall_value = 17'($urandom % 86400);
		i_wall_set = 1'b1;
		fork
			pm.cmd(1);
			@(negedge i_core_clk) i_wall_set = 1'b0;
		join
		note(32'h0, 0);
		note(32'(i_wall_value), 2);
		note(32'(tag_e[5]), 6);
		note(32'h0, 1);
		pm.cmd(1);
		note(32'(i_wall_value), 2);
		for (int i = 0; i < 6; i++) begin
			i_tag_addr = 10'(i);
			@(negedge i_core_clk);
			note(32'(tag_e[i]), 3);
		end
		$display("test tags done");
		// preset, then 16 cycles (one simulated second) hold exactly one step
		for (int i = 0; i < 2; i++) begin
			i_wall_value = (i == 0) ? 17'h1_517f : 17'($urandom % 86400);
			i_wall_set = 1'b1;
			@(negedge i_core_clk);
			i_wall_set = 1'b0;
			repeat (16) @(negedge i_core_clk);
			note((i_wall_value == 17'h1_517f) ? 32'h0000_0000 : 32'(i_wall_value) + 32'h0000_0001, 8);
		end
		$display("test wall clock done");
		pm.cmd(3);
		note(32'h0, 5);
		@(negedge i_core_clk);
		note(32'h1, 5);
		pm.cmd(0);
		pm.cmd(4);
		note(32'h0, 0);
		note(32'h32, 7);
		$display("test outputs done");
		@(negedge i_core_clk);
		final_report();
	end
endmodule // ttl_tracker_tb
